// ===== gpcs_pkg.sv
/*
 * Shared constants, types and register layout of the pin control slice.
 * Assumes an APB master with 8-bit byte addresses and 32-bit data.
 */
package gpcs_pkg;

	// ----------------------------------------------------------------
	// Sizes and register map
	// ----------------------------------------------------------------
	localparam int unsigned NUM_PINS  = 8;
	localparam int unsigned NUM_PORTS = 4;
	localparam int unsigned SYNC_W    = 9;
	localparam int unsigned IDX_SHIFT = 2;

	localparam logic [7:0] IDX_IO_SUPPLY_CONTROL  = 8'h0d;
	localparam logic [7:0] IDX_PIN_LEVEL_READBACK = 8'h0e;
	localparam logic [7:0] IDX_PIN_INPUT_ENABLES  = 8'h0f;
	localparam logic [7:0] IDX_PIN0_OUTPUT_CTL    = 8'h10;

	localparam logic [7:0] IO_SUPPLY_RESET = 8'h09;
	localparam logic [7:0] READBACK_RESET  = 8'h00;
	localparam logic [7:0] IN_ENABLE_RESET = 8'hff;
	localparam logic [7:0] PIN0_CTL_RESET  = 8'h00;

	localparam int unsigned IO_SEL_BIT  = 7;
	localparam int unsigned IO_OV_BIT   = 6;
	localparam int unsigned IO_MODE_LSB = 4;

	localparam logic [1:0] MODE_1V8 = 2'b00;
	localparam logic [1:0] MODE_3V3 = 2'b11;

	// ----------------------------------------------------------------
	// Output source and select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_DEV_STATUS = 3'h4;
	localparam logic [2:0] SRC_TX_PORT    = 3'h6;

	localparam logic [2:0] SEL_RX_LOCK = 3'h4;
	localparam logic [2:0] SEL_RX_PASS = 3'h5;
	localparam logic [2:0] SEL_RX_FV   = 3'h6;
	localparam logic [2:0] SEL_RX_LV   = 3'h7;

	localparam logic [2:0] SEL_ST_LOCK_OR  = 3'h1;
	localparam logic [2:0] SEL_ST_LOCK_AND = 3'h2;
	localparam logic [2:0] SEL_ST_PASS_AND = 3'h3;
	localparam logic [2:0] SEL_ST_FSYNC    = 3'h4;

	localparam logic [2:0] SEL_TX_PASS_AND = 3'h0;
	localparam logic [2:0] SEL_TX_PASS_OR  = 3'h1;
	localparam logic [2:0] SEL_TX_FV       = 3'h2;
	localparam logic [2:0] SEL_TX_LV       = 3'h3;
	localparam logic [2:0] SEL_TX_SYNCED   = 3'h4;
	localparam logic [2:0] SEL_TX_IRQ      = 3'h5;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		GPCS_IDLE = 1'b0,
		GPCS_ACK  = 1'b1
	} gpcs_apb_state_t;

	typedef struct packed {
		logic [2:0] pin0_output_select;
		logic [2:0] pin0_output_source;
		logic       pin0_output_level;
		logic       pin0_output_enable;
	} gpcs_pin0_ctl_t;

	typedef struct packed {
		logic [3:0] remote_pin;
		logic       lock;
		logic       pass;
		logic       frame_valid;
		logic       line_valid;
	} gpcs_rx_port_t;

	typedef struct packed {
		logic frame_valid;
		logic line_valid;
		logic synced;
		logic irq;
	} gpcs_tx_status_t;

endpackage : gpcs_pkg

// ===== gpcs_pin_sync.sv
/*
 * Three-stage synchroniser for pin levels and the supply detector.
 * Assumes inputs are asynchronous to pclk; a level is taken only once
 * the second and third stages agree.
 */
`timescale 1ns/10ps
module gpcs_pin_sync (
	input  wire logic                        pclk,     // Register clock.
	input  wire logic                        presetn,  // Asynchronous reset, low.
	input  wire logic [gpcs_pkg::SYNC_W-1:0] async_in, // Raw asynchronous levels.
	output logic      [gpcs_pkg::SYNC_W-1:0] level     // Filtered levels.
);

	logic [gpcs_pkg::SYNC_W-1:0] s1_reg, s1_next;
	logic [gpcs_pkg::SYNC_W-1:0] s2_reg, s2_next;
	logic [gpcs_pkg::SYNC_W-1:0] s3_reg, s3_next;
	logic [gpcs_pkg::SYNC_W-1:0] level_reg, level_next;
	logic [gpcs_pkg::SYNC_W-1:0] agree;

	always_comb begin
		s1_next    = async_in;
		s2_next    = s1_reg;
		s3_next    = s2_reg;
		agree      = s2_reg ~^ s3_reg;
		level_next = (agree & s3_reg) | (~agree & level_reg);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			level_reg <= '0;
		end else begin
			s1_reg    <= s1_next;
			s2_reg    <= s2_next;
			s3_reg    <= s3_next;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;

endmodule : gpcs_pin_sync

// ===== gpcs_out_mux.sv
/*
 * Combinational source and select multiplexer for the pin 0 output.
 * Assumes all status inputs are synchronous to the register clock.
 */
`timescale 1ns/10ps
module gpcs_out_mux (
	input  wire gpcs_pkg::gpcs_pin0_ctl_t        ctl,        // Pin 0 control fields.
	input  wire gpcs_pkg::gpcs_rx_port_t [3:0]   rx_port,    // Receive port signals.
	input  wire logic                  [3:0]     port_en,    // Enabled receive ports.
	input  wire logic                            frame_sync, // Frame sync signal.
	input  wire gpcs_pkg::gpcs_tx_status_t       tx_status,  // Transmit port status.
	output logic                                 mux_level   // Selected level.
);

	logic [3:0]            lock_v;
	logic [3:0]            pass_v;
	gpcs_pkg::gpcs_rx_port_t port;

	always_comb begin
		for (int i = 0; i < gpcs_pkg::NUM_PORTS; i++) begin
			lock_v[i] = rx_port[i].lock;
			pass_v[i] = rx_port[i].pass;
		end
		port      = rx_port[ctl.pin0_output_source[1:0]];
		// Reserved codes fall back to the register-controlled level.
		mux_level = ctl.pin0_output_level;
		// RQ6: Source code decode.
		case (ctl.pin0_output_source)
			3'h0, 3'h1, 3'h2, 3'h3: begin
				// RQ7: Receive port select.
				if (!ctl.pin0_output_select[2]) begin
					mux_level = port.remote_pin[ctl.pin0_output_select[1:0]];
				end else begin
					case (ctl.pin0_output_select)
						gpcs_pkg::SEL_RX_LOCK: mux_level = port.lock;
						gpcs_pkg::SEL_RX_PASS: mux_level = port.pass;
						gpcs_pkg::SEL_RX_FV:   mux_level = port.frame_valid;
						gpcs_pkg::SEL_RX_LV:   mux_level = port.line_valid;
						default:               mux_level = ctl.pin0_output_level;
					endcase
				end
			end
			gpcs_pkg::SRC_DEV_STATUS: begin
				// RQ8: Lock and pass aggregates over enabled ports, or frame sync.
				case (ctl.pin0_output_select)
					gpcs_pkg::SEL_ST_LOCK_OR:  mux_level = |(lock_v & port_en);
					gpcs_pkg::SEL_ST_LOCK_AND: mux_level = &(lock_v | ~port_en);
					gpcs_pkg::SEL_ST_PASS_AND: mux_level = &(pass_v | ~port_en);
					gpcs_pkg::SEL_ST_FSYNC:    mux_level = frame_sync;
					default:                   mux_level = ctl.pin0_output_level;
				endcase
			end
			gpcs_pkg::SRC_TX_PORT: begin
				// RQ9: Pass aggregates of the enabled receive ports, and transmit port status.
				case (ctl.pin0_output_select)
					gpcs_pkg::SEL_TX_PASS_AND: mux_level = &(pass_v | ~port_en);
					gpcs_pkg::SEL_TX_PASS_OR:  mux_level = |(pass_v & port_en);
					gpcs_pkg::SEL_TX_FV:       mux_level = tx_status.frame_valid;
					gpcs_pkg::SEL_TX_LV:       mux_level = tx_status.line_valid;
					gpcs_pkg::SEL_TX_SYNCED:   mux_level = tx_status.synced;
					// RQ10: Transmit interrupt route.
					gpcs_pkg::SEL_TX_IRQ:      mux_level = tx_status.irq;
					default:                   mux_level = ctl.pin0_output_level;
				endcase
			end
			default: mux_level = ctl.pin0_output_level;
		endcase
	end

endmodule : gpcs_out_mux

// ===== gpcs_top.sv
/*
 * Pin control slice: supply level control, pin level readback, input
 * enables and the pin 0 output multiplexer behind an APB slave.
 * Assumes one register clock, remote and status signals synchronous to
 * it, and pins and the supply detector asynchronous to it.
 */
`timescale 1ns/10ps

// Notes on behaviour
// RQ1: Bit 7 of the supply register selects 1.8V at 0 and 3.3V at 1 for the pins.
// RQ2: With override at 0 both supply controls follow the detector, else the written values.
// RQ3: Bits 5:4 hold the supply mode, 00 for 1.8V and 11 for 3.3V, reading the detector without override.
// RQ4: The readback register is read-only and shows the live level of pins 7 down to 0.
// RQ5: Each pin has an input enable bit, eight in all, reset to enabled.
// RQ6: The source field picks a receive port 0 to 3, device status or the transmit port.
// RQ7: For a receive port the select picks remote pins 0 to 3, lock, pass, frame or line valid.
// RQ8: For device status the select picks OR lock, AND lock, AND pass or frame sync.
// RQ9: For the transmit port the select picks AND pass, OR pass, frame, line valid or synced.
// RQ10: For the transmit port select code 101 routes its interrupt to the pin.
// RQ11: Bit 0 enables the pin 0 output and bit 1 gives the register-controlled level.
// RQ12: Reserved supply bits read zero and drop writes, and a disabled pin is not driven.
module gpcs_top (
	input  wire logic                              pclk,           // Register clock.
	input  wire logic                              presetn,        // Asynchronous reset, low.
	input  wire logic                              psel,           // APB select.
	input  wire logic                              penable,        // APB enable.
	input  wire logic                              pwrite,         // APB direction.
	input  wire logic                      [7:0]   paddr,          // APB byte address.
	input  wire logic                      [31:0]  pwdata,         // APB write data.
	output logic                           [31:0]  prdata,         // APB read data.
	output logic                                   pready,         // APB ready.
	output logic                                   pslverr,        // APB error.
	input  wire logic                      [7:0]   pin_in,         // Pin input levels.
	input  wire logic                              io_level_detect, // Detector, 1 is 3.3V.
	input  wire gpcs_pkg::gpcs_rx_port_t   [3:0]   rx_port,        // Receive port signals.
	input  wire logic                      [3:0]   rx_port_enable, // Enabled receive ports.
	input  wire logic                              frame_sync_signal, // Frame sync.
	input  wire gpcs_pkg::gpcs_tx_status_t         tx_status,      // Transmit port status.
	output logic                                   pin0_out,       // Pin 0 output level.
	output logic                                   pin0_oe,        // Pin 0 output enable.
	output logic                                   high_voltage_io_select, // 1 selects 3.3V.
	output logic                           [1:0]   supply_mode     // Supply mode control.
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	gpcs_pkg::gpcs_apb_state_t st_reg, st_next;
	logic [31:0]               prdata_reg, prdata_next;
	logic                      pready_reg, pready_next;
	logic                      pslverr_reg, pslverr_next;

	logic                      sel_sw_reg, sel_sw_next;
	logic                      ov_reg, ov_next;
	logic [1:0]                mode_sw_reg, mode_sw_next;
	logic [7:0]                ien_reg, ien_next;
	gpcs_pkg::gpcs_pin0_ctl_t  pin0_ctl_reg, pin0_ctl_next;
	logic [7:0]                sts_reg, sts_next;

	logic                      pin0_out_reg, pin0_out_next;
	logic                      pin0_oe_reg, pin0_oe_next;
	logic                      hv_sel_reg, hv_sel_next;
	logic [1:0]                mode_reg, mode_next;

	logic [gpcs_pkg::SYNC_W-1:0] sync_level;
	logic                      det_level;
	logic                      eff_sel;
	logic [1:0]                eff_mode;
	logic                      mux_level;
	logic                      wr_fire;
	logic                      mapped;
	logic [7:0]                rd_byte;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
		reg_hit = (addr == (idx << gpcs_pkg::IDX_SHIFT));
	endfunction : reg_hit

	// ----------------------------------------------------------------
	// Input synchroniser and output multiplexer
	// ----------------------------------------------------------------
	gpcs_pin_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({io_level_detect, pin_in}),
		.level    (sync_level)
	);

	gpcs_out_mux u_mux (
		.ctl        (pin0_ctl_reg),
		.rx_port    (rx_port),
		.port_en    (rx_port_enable),
		.frame_sync (frame_sync_signal),
		.tx_status  (tx_status),
		.mux_level  (mux_level)
	);

	assign det_level = sync_level[gpcs_pkg::NUM_PINS];

	// ----------------------------------------------------------------
	// APB slave and registers
	// ----------------------------------------------------------------
	always_comb begin
		// RQ2: Override picks written or detected supply.
		eff_sel  = ov_reg ? sel_sw_reg : det_level;
		eff_mode = ov_reg ? mode_sw_reg :
		           (det_level ? gpcs_pkg::MODE_3V3 : gpcs_pkg::MODE_1V8);
		mapped   = reg_hit(paddr, gpcs_pkg::IDX_IO_SUPPLY_CONTROL) ||
		           reg_hit(paddr, gpcs_pkg::IDX_PIN_LEVEL_READBACK) ||
		           reg_hit(paddr, gpcs_pkg::IDX_PIN_INPUT_ENABLES) ||
		           reg_hit(paddr, gpcs_pkg::IDX_PIN0_OUTPUT_CTL);
		rd_byte  = 8'h00;
		if (reg_hit(paddr, gpcs_pkg::IDX_IO_SUPPLY_CONTROL)) begin
			// RQ3: Readback shows the effective supply.
			rd_byte[gpcs_pkg::IO_SEL_BIT] = eff_sel;
			rd_byte[gpcs_pkg::IO_OV_BIT]  = ov_reg;
			rd_byte[gpcs_pkg::IO_MODE_LSB +: 2] = eff_mode;
		end else if (reg_hit(paddr, gpcs_pkg::IDX_PIN_LEVEL_READBACK)) begin
			// RQ4: Live pin levels.
			rd_byte = sts_reg;
		end else if (reg_hit(paddr, gpcs_pkg::IDX_PIN_INPUT_ENABLES)) begin
			rd_byte = ien_reg;
		end else if (reg_hit(paddr, gpcs_pkg::IDX_PIN0_OUTPUT_CTL)) begin
			rd_byte = pin0_ctl_reg;
		end

		st_next      = st_reg;
		pready_next  = 1'b0;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		case (st_reg)
			gpcs_pkg::GPCS_IDLE: begin
				if (psel && !penable) begin
					st_next      = gpcs_pkg::GPCS_ACK;
					pready_next  = 1'b1;
					prdata_next  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
					pslverr_next = !mapped;
				end
			end
			gpcs_pkg::GPCS_ACK: begin
				st_next     = gpcs_pkg::GPCS_IDLE;
				prdata_next = 32'h0000_0000;
			end
			default: st_next = gpcs_pkg::GPCS_IDLE;
		endcase

		wr_fire       = (st_reg == gpcs_pkg::GPCS_ACK) && psel && penable &&
		                pwrite && pready_reg;
		sel_sw_next   = sel_sw_reg;
		ov_next       = ov_reg;
		mode_sw_next  = mode_sw_reg;
		ien_next      = ien_reg;
		pin0_ctl_next = pin0_ctl_reg;
		if (wr_fire && reg_hit(paddr, gpcs_pkg::IDX_IO_SUPPLY_CONTROL)) begin
			// RQ1: Stored voltage select.
			sel_sw_next  = pwdata[gpcs_pkg::IO_SEL_BIT];
			ov_next      = pwdata[gpcs_pkg::IO_OV_BIT];
			// RQ12: Only bits 7:4 are stored.
			mode_sw_next = pwdata[gpcs_pkg::IO_MODE_LSB +: 2];
		end
		if (wr_fire && reg_hit(paddr, gpcs_pkg::IDX_PIN_INPUT_ENABLES)) begin
			ien_next = pwdata[7:0];
		end
		if (wr_fire && reg_hit(paddr, gpcs_pkg::IDX_PIN0_OUTPUT_CTL)) begin
			pin0_ctl_next = pwdata[7:0];
		end
		// RQ5: Disabled inputs read as zero.
		sts_next = sync_level[gpcs_pkg::NUM_PINS-1:0] & ien_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg       <= gpcs_pkg::GPCS_IDLE;
			prdata_reg   <= 32'h0000_0000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			sel_sw_reg   <= gpcs_pkg::IO_SUPPLY_RESET[gpcs_pkg::IO_SEL_BIT];
			ov_reg       <= gpcs_pkg::IO_SUPPLY_RESET[gpcs_pkg::IO_OV_BIT];
			mode_sw_reg  <= gpcs_pkg::IO_SUPPLY_RESET[gpcs_pkg::IO_MODE_LSB +: 2];
			ien_reg      <= gpcs_pkg::IN_ENABLE_RESET;
			pin0_ctl_reg <= gpcs_pkg::PIN0_CTL_RESET;
			sts_reg      <= gpcs_pkg::READBACK_RESET;
		end else begin
			st_reg       <= st_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			sel_sw_reg   <= sel_sw_next;
			ov_reg       <= ov_next;
			mode_sw_reg  <= mode_sw_next;
			ien_reg      <= ien_next;
			pin0_ctl_reg <= pin0_ctl_next;
			sts_reg      <= sts_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin and supply outputs
	// ----------------------------------------------------------------
	always_comb begin
		// RQ11: Enable gates the pin driver.
		pin0_oe_next  = pin0_ctl_reg.pin0_output_enable;
		// RQ12: Undriven pin holds low.
		pin0_out_next = pin0_ctl_reg.pin0_output_enable & mux_level;
		hv_sel_next   = eff_sel;
		mode_next     = eff_mode;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin0_out_reg <= 1'b0;
			pin0_oe_reg  <= 1'b0;
			hv_sel_reg   <= 1'b0;
			mode_reg     <= gpcs_pkg::MODE_1V8;
		end else begin
			pin0_out_reg <= pin0_out_next;
			pin0_oe_reg  <= pin0_oe_next;
			hv_sel_reg   <= hv_sel_next;
			mode_reg     <= mode_next;
		end
	end

	assign prdata                 = prdata_reg;
	assign pready                 = pready_reg;
	assign pslverr                = pslverr_reg;
	assign pin0_out               = pin0_out_reg;
	assign pin0_oe                = pin0_oe_reg;
	assign high_voltage_io_select = hv_sel_reg;
	assign supply_mode            = mode_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic io_rd;
	logic sts_rd;
	assign io_rd  = pready_reg && !pwrite && reg_hit(paddr, gpcs_pkg::IDX_IO_SUPPLY_CONTROL);
	assign sts_rd = pready_reg && !pwrite && reg_hit(paddr, gpcs_pkg::IDX_PIN_LEVEL_READBACK);

	a_detect_drives_supply: assert property ( // RQ2
		!ov_reg ##1 !ov_reg |-> high_voltage_io_select == $past(det_level) &&
		supply_mode == {2{$past(det_level)}})
		else $error("supply outputs do not follow detector");

	a_override_uses_sw: assert property ( // RQ1
		ov_reg |=> high_voltage_io_select == $past(sel_sw_reg) &&
		supply_mode == $past(mode_sw_reg))
		else $error("override does not apply written supply");

	a_mode_readback: assert property ( // RQ3
		io_rd && $past(!ov_reg) |-> prdata[5:4] == {2{$past(det_level)}} &&
		prdata[7] == $past(det_level))
		else $error("supply readback not detected level");

	a_reserved_zero: assert property ( // RQ12
		io_rd |-> prdata[3:0] == 4'h0)
		else $error("reserved supply bits not zero");

	a_readback_value: assert property ( // RQ4
		sts_rd |-> prdata[7:0] == $past(sts_reg) && !pslverr)
		else $error("pin readback mismatch");

	a_input_disable: assert property ( // RQ5
		(sts_reg & ~$past(ien_reg)) == 8'h00)
		else $error("disabled inputs read nonzero");

	a_pin_undriven: assert property ( // RQ12
		!pin0_ctl_reg.pin0_output_enable |=> !pin0_oe && !pin0_out)
		else $error("disabled pin is driven");

	a_reg_level_drive: assert property ( // RQ11
		pin0_ctl_reg.pin0_output_enable && pin0_ctl_reg.pin0_output_source == 3'h5
		|=> pin0_oe && pin0_out == $past(pin0_ctl_reg.pin0_output_level))
		else $error("register level not driven");

	a_rx_lock_route: assert property ( // RQ7
		pin0_ctl_reg.pin0_output_enable && pin0_ctl_reg.pin0_output_source == 3'h2 &&
		pin0_ctl_reg.pin0_output_select == gpcs_pkg::SEL_RX_LOCK
		|=> pin0_out == $past(rx_port[2].lock))
		else $error("port lock not routed");

	a_status_or_lock: assert property ( // RQ8
		pin0_ctl_reg.pin0_output_enable &&
		pin0_ctl_reg.pin0_output_source == gpcs_pkg::SRC_DEV_STATUS &&
		pin0_ctl_reg.pin0_output_select == gpcs_pkg::SEL_ST_LOCK_OR
		|=> pin0_out == $past(|({rx_port[3].lock, rx_port[2].lock, rx_port[1].lock,
		rx_port[0].lock} & rx_port_enable)))
		else $error("lock OR not routed");

	a_tx_irq_route: assert property ( // RQ10
		pin0_ctl_reg.pin0_output_enable &&
		pin0_ctl_reg.pin0_output_source == gpcs_pkg::SRC_TX_PORT &&
		pin0_ctl_reg.pin0_output_select == gpcs_pkg::SEL_TX_IRQ
		|=> pin0_out == $past(tx_status.irq))
		else $error("transmit interrupt not routed");

	a_tx_synced_route: assert property ( // RQ9
		pin0_ctl_reg.pin0_output_enable &&
		pin0_ctl_reg.pin0_output_source == gpcs_pkg::SRC_TX_PORT &&
		pin0_ctl_reg.pin0_output_select == gpcs_pkg::SEL_TX_SYNCED
		|=> pin0_out == $past(tx_status.synced))
		else $error("synced status not routed");

	a_apb_one_wait: assert property (
		st_reg == gpcs_pkg::GPCS_IDLE && psel && !penable |=> pready ##1 !pready)
		else $error("APB ready not one cycle after setup");

	c_override_write: cover property (wr_fire && pwdata[gpcs_pkg::IO_OV_BIT] &&
		reg_hit(paddr, gpcs_pkg::IDX_IO_SUPPLY_CONTROL));
	c_tx_drive: cover property (pin0_oe && pin0_out &&
		pin0_ctl_reg.pin0_output_source == gpcs_pkg::SRC_TX_PORT);
	c_unmapped: cover property (pready && pslverr);

endmodule : gpcs_top

// ===== gpcs_pin_model.sv
/*
 * Partner model: the outside logic and sensors on the eight pins.
 * Assumes the bench gives the level that each pin has when nobody drives it.
 */
`timescale 1ns/10ps
module gpcs_pin_model (
	input  wire logic       pin0_out,  // Level driven by the slice.
	input  wire logic       pin0_oe,   // High while the slice drives pin 0.
	input  wire logic [7:0] ext_level, // Level the outside puts on each pin.
	output logic      [7:0] pin_level  // Resolved pin levels.
);
	assign pin_level = {ext_level[7:1], pin0_oe ? pin0_out : ext_level[0]};
endmodule : gpcs_pin_model

// ===== tb_top.sv
/*
 * Self-checking bench for the pin control slice, driven over APB.
 * Assumes a zero-wait APB slave at byte addresses 0x34 to 0x40.
 */
`timescale 1ns/10ps
module tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                          pclk = 1'b0, presetn = 1'b0, det = 1'b1, fsync = 1'b1;
	logic                          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]                    paddr = 8'h00, ext = 8'h00, pins, q;
	logic [31:0]                   pwdata = 32'h0, prdata;
	logic                          pready, pslverr, pin0_out, pin0_oe, hv_sel, e;
	logic [1:0]                    mode;
	logic [3:0]                    ren = 4'h9;
	gpcs_pkg::gpcs_rx_port_t [3:0] rxp = 32'h0cf0a55a;
	gpcs_pkg::gpcs_tx_status_t     txs = 4'ha;
	int                            fail_count = 0, comparisons = 0;
	// Each entry is the pin 0 control byte, then the expected pin0_out level.
	localparam logic [11:0] MUX [30] = '{12'h011, 12'h210, 12'h251, 12'h691, 12'h811,
		12'h850, 12'ha51, 12'hc11, 12'he51, 12'he10, 12'had1, 12'h311, 12'h511, 12'h710,
		12'h911, 12'hb31, 12'hb10, 12'h190, 12'h391, 12'h591, 12'h790, 12'h991, 12'hb90,
		12'h171, 12'h150, 12'h1f1, 12'h020, 12'h131, 12'hbb0, 12'hdb1};

	always #4 pclk = ~pclk;

	gpcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pins), .io_level_detect(det), .rx_port(rxp),
		.rx_port_enable(ren), .frame_sync_signal(fsync), .tx_status(txs),
		.pin0_out(pin0_out), .pin0_oe(pin0_oe), .high_voltage_io_select(hv_sel),
		.supply_mode(mode));
	gpcs_pin_model partner (.pin0_out(pin0_out), .pin0_oe(pin0_oe), .ext_level(ext),
		.pin_level(pins));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			report_and_stop;
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(0, 8'h34, 8'h00, q, e);
		chk("supply", q, 8'hb0);
		chk("select", {7'h0, hv_sel}, 8'h01);
		chk("mode", {6'h0, mode}, 8'h03);
		apb(0, 8'h3c, 8'h00, q, e);
		chk("enables", q, 8'hff);
		apb(0, 8'h40, 8'h00, q, e);
		chk("pin0 ctl", q, 8'h00);
		apb(1, 8'h34, 8'h4f, q, e);
		apb(0, 8'h34, 8'h00, q, e);
		chk("supply ov", q, 8'h40);
		chk("mode ov", {6'h0, mode}, 8'h00);
		chk("select ov", {7'h0, hv_sel}, 8'h00);
		apb(1, 8'h34, 8'h00, q, e);
		det <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(0, 8'h34, 8'h00, q, e);
		chk("supply det", q, 8'h00);
		ext <= 8'ha5;
		repeat (8) @(posedge pclk);
		apb(1, 8'h38, 8'hff, q, e);
		apb(0, 8'h38, 8'h00, q, e);
		chk("readback", q, 8'ha5);
		apb(1, 8'h3c, 8'h0f, q, e);
		apb(0, 8'h3c, 8'h00, q, e);
		chk("enables", q, 8'h0f);
		apb(0, 8'h38, 8'h00, q, e);
		chk("gated", q, 8'h05);
		apb(0, 8'h44, 8'h00, q, e);
		chk("unmapped", {e, q[6:0]}, 8'h80);
		foreach (MUX[i]) begin
			apb(1, 8'h40, MUX[i][11:4], q, e);
			@(posedge pclk);
			chk("pin0_out", {7'h0, pin0_out}, {7'h0, MUX[i][0]});
			chk("pin0_oe", {7'h0, pin0_oe}, {7'h0, MUX[i][4]});
		end
		report_and_stop;
	end
endmodule : tb_top
